// ---- psp_pkg.sv ----
// shared constants for the parallel slave port and its external master
package psp_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CTL_W = 3;
  // cpu register offsets
  localparam logic [7:0] OFS_DATA_LATCH = 8'h08;
  localparam logic [7:0] OFS_CTL_LATCH = 8'h09;
  localparam logic [7:0] OFS_DATA_DIR = 8'h88;
  localparam logic [7:0] OFS_CTL_DIR_STAT = 8'h89;
  localparam logic [7:0] OFS_ANALOG_CFG = 8'h9f;
  // control_direction_status fields
  localparam int unsigned BIT_IN_FULL = 7;
  localparam int unsigned BIT_OUT_FULL = 6;
  localparam int unsigned BIT_OVERRUN = 5;
  localparam int unsigned BIT_SLAVE_SEL = 4;
  localparam int unsigned BIT_CTL_DIR_MSB = 2;
  // control pin positions
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;
  // reset values
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [2:0] RST_CTL_DIR = 3'h7;
  localparam logic [7:0] RST_ANALOG_CFG = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;
  // analog_pin_config low four bits at or above this make control pins digital
  localparam logic [3:0] PCFG_DIGITAL_MIN = 4'h8;
  // external strobe timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned STROBE_NS = 150;
  localparam int unsigned STROBE_CYC =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_NS = 100;
  localparam int unsigned RECOV_CYC =
    (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- psp_if.sv ----
// pin-level link between the port device and the external master
`timescale 1ns/1ps
interface psp_if;
  logic [7:0] data_dev_out;
  logic [7:0] data_dev_oe_n;
  logic [7:0] data_host_out;
  logic [7:0] data_host_oe_n;
  logic [2:0] ctl_dev_out;
  logic [2:0] ctl_dev_oe_n;
  logic [2:0] ctl_host_out;
  logic [2:0] ctl_host_oe_n;
  logic [7:0] data_pins;
  logic [2:0] control_pins;

  // resolve each wire, weak pull-up when nobody drives
  assign data_pins = (~data_dev_oe_n & data_dev_out)
                   | (data_dev_oe_n & ~data_host_oe_n & data_host_out)
                   | (data_dev_oe_n & data_host_oe_n);
  assign control_pins = (~ctl_dev_oe_n & ctl_dev_out)
                      | (ctl_dev_oe_n & ~ctl_host_oe_n & ctl_host_out)
                      | (ctl_dev_oe_n & ctl_host_oe_n);

  modport dev (
    input data_pins, control_pins,
    output data_dev_out, data_dev_oe_n, ctl_dev_out, ctl_dev_oe_n
  );
  modport host (
    input data_pins, control_pins,
    output data_host_out, data_host_oe_n, ctl_host_out, ctl_host_oe_n
  );
endinterface

// ---- psp_dev.sv ----
// parallel slave port device: data port, control port and cpu registers
//
// Function
// - eight data pins, each direction separately set
// - slave select bit turns port into bus
// - three control pins, each direction separately set
// - software sets control directions to input
// - software makes control pins digital first
// - analog control pins read as zero
// - direction bits drive pins even when analog
// - control pins start analog after reset
// - input full flag, bit seven
// - output full flag, bit six
// - overrun set on unread write, software clears
// - bit four selects slave mode, resets zero
// - control direction bits, bit three zero
// - selected read drives output latch outward
// - selected write captures bus into latch
// - chip select low enables strobes
// - write taken at first both-low detection
// - read taken at first both-low detection
// - strobes synchronised to the device clock
// - data direction resets to all inputs
`timescale 1ns/1ps
module psp_dev (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_port_event,
  psp_if.dev pins
);
  logic [7:0] data_out_r;
  logic [7:0] data_in_r;
  logic [7:0] data_dir_r;
  logic [2:0] ctl_latch_r;
  logic [2:0] ctl_dir_r;
  logic [7:0] analog_cfg_r;
  logic slave_sel_r;
  logic in_full_r;
  logic out_full_r;
  logic overrun_r;
  logic [7:0] data_meta_r;
  logic [7:0] data_sync_r;
  logic [2:0] ctl_meta_r;
  logic [2:0] ctl_sync_r;
  logic wr_seen_r;
  logic rd_seen_r;
  logic [7:0] data_oe_n_r;
  logic [2:0] ctl_oe_n_r;
  logic [7:0] rdata_r;
  logic event_r;
  logic ctl_digital;
  logic wr_act;
  logic rd_act;
  logic ext_wr;
  logic ext_rd;
  logic cpu_rd_data;
  logic cpu_wr_data;
  logic cpu_wr_stat;
  logic [7:0] rdata_nxt;

  // two-stage synchronisers on every pin input
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      data_meta_r <= 8'hff;
      data_sync_r <= 8'hff;
      ctl_meta_r <= 3'h7;
      ctl_sync_r <= 3'h7;
    end else begin
      data_meta_r <= pins.data_pins;
      data_sync_r <= data_meta_r;
      ctl_meta_r <= pins.control_pins;
      ctl_sync_r <= ctl_meta_r;
    end
  end

  // strobe decode, only while selected and in slave mode
  assign ctl_digital = analog_cfg_r[3:0] >= psp_pkg::PCFG_DIGITAL_MIN;
  assign wr_act = slave_sel_r & ~ctl_sync_r[psp_pkg::PIN_CS]
                & ~ctl_sync_r[psp_pkg::PIN_WR];
  assign rd_act = slave_sel_r & ~ctl_sync_r[psp_pkg::PIN_CS]
                & ~ctl_sync_r[psp_pkg::PIN_RD];
  assign ext_wr = wr_act & ~wr_seen_r;
  assign ext_rd = rd_act & ~rd_seen_r;

  // remember an active strobe so each access counts once
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= wr_act;
      rd_seen_r <= rd_act;
    end
  end

  // cpu access decode
  assign cpu_rd_data = i_rd & (i_addr == psp_pkg::OFS_DATA_LATCH);
  assign cpu_wr_data = i_wr & (i_addr == psp_pkg::OFS_DATA_LATCH);
  assign cpu_wr_stat = i_wr & (i_addr == psp_pkg::OFS_CTL_DIR_STAT);

  // writable configuration registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      data_out_r <= psp_pkg::RST_LATCH;
      data_dir_r <= psp_pkg::RST_DATA_DIR;
      ctl_latch_r <= 3'h0;
      ctl_dir_r <= psp_pkg::RST_CTL_DIR;
      analog_cfg_r <= psp_pkg::RST_ANALOG_CFG;
      slave_sel_r <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        psp_pkg::OFS_DATA_LATCH: begin
          data_out_r <= i_wdata;
        end
        psp_pkg::OFS_CTL_LATCH: begin
          ctl_latch_r <= i_wdata[2:0];
        end
        psp_pkg::OFS_DATA_DIR: begin
          data_dir_r <= i_wdata;
        end
        psp_pkg::OFS_CTL_DIR_STAT: begin
          slave_sel_r <= i_wdata[psp_pkg::BIT_SLAVE_SEL];
          ctl_dir_r <= i_wdata[2:0];
        end
        psp_pkg::OFS_ANALOG_CFG: begin
          analog_cfg_r <= i_wdata;
        end
        default: begin
          ctl_latch_r <= ctl_latch_r;
        end
      endcase
    end
  end

  // input word: captured on each external write
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      data_in_r <= psp_pkg::RST_LATCH;
    end else if (ext_wr) begin
      data_in_r <= data_sync_r;
    end
  end

  // input full: set by external write wins over cpu read clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      in_full_r <= 1'b0;
    end else if (ext_wr) begin
      in_full_r <= 1'b1;
    end else if (cpu_rd_data) begin
      in_full_r <= 1'b0;
    end
  end

  // output full: cpu write in slave mode sets, external read clears
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      out_full_r <= 1'b0;
    end else if (cpu_wr_data && slave_sel_r) begin
      out_full_r <= 1'b1;
    end else if (ext_rd) begin
      out_full_r <= 1'b0;
    end
  end

  // overrun: write onto an unread word; software writes zero to clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      overrun_r <= 1'b0;
    end else if (ext_wr && in_full_r && !cpu_rd_data) begin
      overrun_r <= 1'b1;
    end else if (cpu_wr_stat && !i_wdata[psp_pkg::BIT_OVERRUN]) begin
      overrun_r <= 1'b0;
    end
  end

  // one-cycle event on each external transfer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      event_r <= 1'b0;
    end else begin
      event_r <= ext_wr | ext_rd;
    end
  end

  // pin drivers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      data_oe_n_r <= 8'hff;
      ctl_oe_n_r <= 3'h7;
    end else begin
      if (slave_sel_r) begin
        data_oe_n_r <= {8{~rd_act}};
      end else begin
        data_oe_n_r <= data_dir_r;
      end
      ctl_oe_n_r <= ctl_dir_r;
    end
  end

  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    case (i_addr)
      psp_pkg::OFS_DATA_LATCH: begin
        rdata_nxt = slave_sel_r ? data_in_r : data_sync_r;
      end
      psp_pkg::OFS_CTL_LATCH: begin
        rdata_nxt = {5'h00, ctl_digital ? ctl_sync_r : 3'h0};
      end
      psp_pkg::OFS_DATA_DIR: begin
        rdata_nxt = data_dir_r;
      end
      psp_pkg::OFS_CTL_DIR_STAT: begin
        rdata_nxt = {in_full_r, out_full_r, overrun_r, slave_sel_r,
                     1'b0, ctl_dir_r};
      end
      psp_pkg::OFS_ANALOG_CFG: begin
        rdata_nxt = analog_cfg_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // read data register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_rdata = rdata_r;
  assign o_port_event = event_r;
  assign pins.data_dev_out = data_out_r;
  assign pins.data_dev_oe_n = data_oe_n_r;
  assign pins.ctl_dev_out = ctl_latch_r;
  assign pins.ctl_dev_oe_n = ctl_oe_n_r;
endmodule

// ---- psp_host.sv ----
// external 8-bit bus master that reads and writes the slave port
`timescale 1ns/1ps
module psp_host #(
  parameter int unsigned STROBE_CYC = psp_pkg::STROBE_CYC,
  parameter int unsigned RECOV_CYC = psp_pkg::RECOV_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_wr,
  input wire logic i_req_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_busy,
  psp_if.host pins
);
  typedef enum logic [3:0] {
    PSPH_IDLE = 4'h1,
    PSPH_WRITE = 4'h2,
    PSPH_READ = 4'h4,
    PSPH_RECOV = 4'h8
  } psph_state_e;

  psph_state_e state_r;
  logic [7:0] cnt_r;
  logic [7:0] data_r;
  logic data_oe_n_r;
  logic [2:0] ctl_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic busy_r;

  // strobe sequencer: select and strobe low together, then recover
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r <= PSPH_IDLE;
      cnt_r <= 8'h00;
      data_r <= 8'h00;
      data_oe_n_r <= 1'b1;
      ctl_r <= 3'h7;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      case (state_r)
        PSPH_IDLE: begin
          cnt_r <= 8'(STROBE_CYC - 1);
          if (i_req_wr) begin
            state_r <= PSPH_WRITE;
            data_r <= i_wdata;
            data_oe_n_r <= 1'b0;
            ctl_r <= 3'h7 & ~(3'h1 << psp_pkg::PIN_WR)
                   & ~(3'h1 << psp_pkg::PIN_CS);
            busy_r <= 1'b1;
          end else if (i_req_rd) begin
            state_r <= PSPH_READ;
            ctl_r <= 3'h7 & ~(3'h1 << psp_pkg::PIN_RD)
                   & ~(3'h1 << psp_pkg::PIN_CS);
            busy_r <= 1'b1;
          end
        end
        PSPH_WRITE, PSPH_READ: begin
          if (cnt_r == 8'h00) begin
            if (state_r == PSPH_READ) begin
              rdata_r <= pins.data_pins;
              rvalid_r <= 1'b1;
            end
            state_r <= PSPH_RECOV;
            ctl_r <= 3'h7;
            data_oe_n_r <= 1'b1;
            cnt_r <= 8'(RECOV_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        PSPH_RECOV: begin
          if (cnt_r == 8'h00) begin
            state_r <= PSPH_IDLE;
            busy_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= PSPH_IDLE;
        end
      endcase
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_busy = busy_r;
  assign pins.data_host_out = data_r;
  assign pins.data_host_oe_n = {8{data_oe_n_r}};
  assign pins.ctl_host_out = ctl_r;
  assign pins.ctl_host_oe_n = 3'h0; // strobes always driven
endmodule

// ---- psp_properties.sv ----
// concurrent checks on the link between the port device and its master
`timescale 1ns/1ps
module psp_properties (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] data_pins,
  input wire logic [2:0] control_pins,
  input wire logic [7:0] data_dev_out,
  input wire logic [7:0] data_dev_oe_n,
  input wire logic [2:0] ctl_dev_oe_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // strobe aliases, all active low
  wire rd_n = control_pins[psp_pkg::PIN_RD];
  wire wr_n = control_pins[psp_pkg::PIN_WR];
  wire cs_n = control_pins[psp_pkg::PIN_CS];

  chk_reset_dirs:
  assert property ($rose(i_rst_n) |->
    data_dev_oe_n == 8'hff && ctl_dev_oe_n == 3'h7)
    else $error("directions not all input after reset");
  chk_drive_on_read:
  assert property ($fell(data_dev_oe_n[0]) |-> !rd_n && !cs_n)
    else $error("data drivers on without selected read");
  chk_drive_timely:
  assert property ($fell(rd_n) && !cs_n |-> ##[1:5] data_dev_oe_n == 8'h00)
    else $error("selected read not answered");
  chk_drive_release:
  assert property ($rose(rd_n) |-> ##[1:4] data_dev_oe_n == 8'hff)
    else $error("data drivers kept on after read");
  chk_latch_steady:
  assert property (data_dev_oe_n == 8'h00 && $past(data_dev_oe_n) == 8'h00
    |-> $stable(data_dev_out))
    else $error("output latch changed during read");
  chk_no_drive_wr:
  assert property (!wr_n |-> data_dev_oe_n == 8'hff)
    else $error("device drives data during write");
  chk_strobe_sel:
  assert property (!wr_n || !rd_n |-> !cs_n)
    else $error("strobe without chip select");
  chk_write_hold:
  assert property ($fell(wr_n) |-> !wr_n [*6])
    else $error("write strobe too short");
  chk_write_data:
  assert property (!wr_n && $past(!wr_n) |-> $stable(data_pins))
    else $error("data moved during write");
endmodule

// ---- tb.sv ----
// self-checking bench joining the port device and the external master
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, wr, rd, ev, h_wr, h_rd, h_rv, h_busy;
  logic [7:0] addr, wdata, rdata, h_wdata, h_rdata;
  int mismatches, total_checks, ev_n, rv_n;
  psp_if bus();
  psp_dev i_psp_dev (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_port_event(ev), .pins(bus.dev));
  psp_host i_psp_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_req_wr(h_wr),
    .i_req_rd(h_rd), .i_wdata(h_wdata), .o_rdata(h_rdata),
    .o_rvalid(h_rv), .o_busy(h_busy), .pins(bus.host));
  psp_properties u_chk (.i_core_clk(clk), .i_rst_n(rst_n),
    .data_pins(bus.data_pins), .control_pins(bus.control_pins),
    .data_dev_out(bus.data_dev_out), .data_dev_oe_n(bus.data_dev_oe_n),
    .ctl_dev_oe_n(bus.ctl_dev_oe_n));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count port events and master read-valid pulses
  always @(posedge clk) begin
    if (ev === 1'b1) ev_n++;
    if (h_rv === 1'b1) rv_n++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic cw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // register read, data judged in the following cycle
  task automatic cr(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // external write or read through the master, bounded wait
  task automatic hx(input logic w, input logic [7:0] d);
    @(posedge clk);
    h_wr <= w;
    h_rd <= !w;
    h_wdata <= d;
    @(posedge clk);
    h_wr <= 1'b0;
    h_rd <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40 && h_busy !== 1'b0; i++) @(posedge clk);
    if (h_busy !== 1'b0) begin
      mismatches++;
      $display("wrong value at %0t: master stuck busy", $time);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset;
    cr(8'h88, 8'hff);
    cr(8'h89, 8'h07);
    cr(8'h9f, 8'h00);
    cr(8'h09, 8'h00);
    cr(8'h55, 8'h00);
    cw(8'h89, 8'h0f);
    cr(8'h89, 8'h07);
    $display("test reset done");
  endtask
  task automatic t_port;
    cw(8'h88, 8'h0f);
    cw(8'h08, 8'h5a);
    repeat (4) @(posedge clk);
    #1 chk(bus.data_pins, 8'h5f);
    cr(8'h08, 8'h5f);
    cw(8'h89, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, bus.ctl_dev_oe_n}, 8'h03);
    cr(8'h09, 8'h00);
    cw(8'h9f, 8'h08);
    repeat (3) @(posedge clk);
    cr(8'h09, 8'h03);
    cw(8'h88, 8'hff);
    cw(8'h89, 8'h07);
    $display("test port mode done");
  endtask
  task automatic t_slave_wr;
    int n;
    cw(8'h89, 8'h17);
    cr(8'h89, 8'h17);
    n = ev_n;
    hx(1'b1, 8'ha5);
    chk(8'(ev_n - n), 8'h01);
    cr(8'h89, 8'h97);
    hx(1'b1, 8'h3c);
    cr(8'h89, 8'hb7);
    cr(8'h08, 8'h3c);
    cr(8'h89, 8'h37);
    cw(8'h89, 8'h17);
    cr(8'h89, 8'h17);
    chk(8'(rv_n), 8'h00);
    $display("test slave write done");
  endtask
  task automatic t_slave_rd;
    int n;
    cw(8'h08, 8'hc3);
    cr(8'h89, 8'h57);
    n = ev_n;
    hx(1'b0, 8'h00);
    chk(h_rdata, 8'hc3);
    chk(8'(rv_n), 8'h01);
    chk(8'(ev_n - n), 8'h01);
    cr(8'h89, 8'h17);
    $display("test slave read done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial begin
    {rst_n, wr, rd, h_wr, h_rd} = 5'h00;
    {addr, wdata, h_wdata} = 24'h000000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_port();
    t_slave_wr();
    t_slave_rd();
    wrap_up();
  end
endmodule
